// ---- design/udils_consts.svh ----
// constants for the usb descriptor and input limit select block
`ifndef UDILS_CONSTS_SVH
`define UDILS_CONSTS_SVH
`define UDILS_DESC_LEN        8'h12
`define UDILS_DESC_TYPE_DEV   8'h01
`define UDILS_BCD_USB         16'h0200
`define UDILS_DEV_CLASS       8'h00
`define UDILS_MAX_PKT0        8'h08
`define UDILS_BCD_DEVICE      16'h0100
`define UDILS_STR_NONE        8'h00
`define UDILS_STR_PRODUCT     8'h01
`define UDILS_NUM_CONFIG      8'h01
`define UDILS_REG_INLIM       8'h0a
`define UDILS_REG_BATCTL      8'h10
`define UDILS_REG_VID_LO      8'h20
`define UDILS_REG_VID_HI      8'h21
`define UDILS_REG_PID_LO      8'h22
`define UDILS_REG_PID_HI      8'h23
`define UDILS_REG_STATUS      8'h24
`define UDILS_SEL_LSB         0
`define UDILS_SEL_W           3
`define UDILS_CUSTOM_INPUT_LIMIT_LSB        3
`define UDILS_CUSTOM_INPUT_LIMIT_W          3
`define UDILS_VSYS_LSB        6
`define UDILS_VSYS_W          2
`define UDILS_BAT_THR_BIT     7
`define UDILS_SEL_100MA       3'h0
`define UDILS_SEL_500MA       3'h1
`define UDILS_SEL_CUSTOM      3'h7
`define UDILS_INLIM_RESET     8'h00
`define UDILS_BATCTL_RESET    8'h00
`define UDILS_VID_RESET       16'h0000
`define UDILS_PID_RESET       16'h0000
`endif

// ---- design/udils_pkg.sv ----
// types for the usb descriptor and input limit select block
package udils_pkg;
    typedef enum logic [1:0] {UDILS_ENUM_IDLE, UDILS_ENUM_LOW, UDILS_ENUM_HIGH} udils_enum_t;
    typedef enum {UDILS_TX_IDLE, UDILS_TX_SEND} udils_tx_t;
endpackage

// ---- design/udils_desc_rom.sv ----
// device descriptor byte table with programmable vendor and product ids
`timescale 1ns/1ps
`include "udils_consts.svh"
module udils_desc_rom
(
    input  wire logic [4:0]  idx,    // byte index into descriptor
    input  wire logic [15:0] vid,    // programmed vendor id
    input  wire logic [15:0] pid,    // programmed product id
    output logic      [7:0]  data    // descriptor byte at idx
);
    // byte table, multi-byte fields least significant byte first
    always_comb
    begin
        case (idx)
            5'h00:   data = `UDILS_DESC_LEN;
            5'h01:   data = `UDILS_DESC_TYPE_DEV;
            5'h02:   data = 8'(`UDILS_BCD_USB & 16'h00ff);
            5'h03:   data = 8'(`UDILS_BCD_USB >> 8);
            5'h04:   data = `UDILS_DEV_CLASS;
            5'h05:   data = `UDILS_DEV_CLASS;
            5'h06:   data = `UDILS_DEV_CLASS;
            5'h07:   data = `UDILS_MAX_PKT0;
            5'h08:   data = vid[7:0];
            5'h09:   data = vid[15:8];
            5'h0a:   data = pid[7:0];
            5'h0b:   data = pid[15:8];
            5'h0c:   data = 8'(`UDILS_BCD_DEVICE & 16'h00ff);
            5'h0d:   data = 8'(`UDILS_BCD_DEVICE >> 8);
            5'h0e:   data = `UDILS_STR_NONE;
            5'h0f:   data = `UDILS_STR_PRODUCT;
            5'h10:   data = `UDILS_STR_NONE;
            5'h11:   data = `UDILS_NUM_CONFIG;
            default: data = 8'h00;                     // past the end
        endcase
    end
endmodule

// ---- design/udils_top.sv ----
// input limit selection, protection control and descriptor streaming
`timescale 1ns/1ps
`include "udils_consts.svh"
// How it works
// - descriptor length 18, type device
// - usb release 2.00 at bytes two-three
// - class, subclass, protocol all zero
// - endpoint zero packet size eight
// - vendor and product ids from registers
// - device release 1.00
// - no manufacturer or serial string, product one
// - one configuration in last byte
// - overvoltage: interrupt, charger off, switch closed
// - detected adapter loads input limit select
// - software write overrides selected limit
// - custom code applies custom limit field
// - usb starts 100ma, enumeration picks 100/500
// - die overtemp blocks input, battery supplies
// - battery control bit7 selects threshold set
module udils_top
(
    input  wire logic                 clk,            // 250 MHz clock
    input  wire logic                 rst,            // sync reset, active high
    input  wire logic                 reg_wr,         // register write strobe
    input  wire logic                 reg_rd,         // register read strobe
    input  wire logic [7:0]           reg_addr,       // register address
    input  wire logic [7:0]           reg_wdata,      // register write data
    output logic      [7:0]           reg_rdata,      // registered read data
    input  wire logic                 adapter_det,    // pulse: adapter type detected
    input  wire logic [2:0]           adapter_sel,    // limit code for detected adapter
    input  wire logic                 usb_port,       // pulse: usb 2.0 port detected
    input  wire logic                 enum_done,      // pulse: enumeration finished
    input  wire logic                 host_high_pwr,  // host is high power at enum_done
    input  wire logic                 ovp_pin,        // async overvoltage comparator
    input  wire logic                 overtemp_pin,   // async die limit plus 20 comparator
    input  wire logic                 desc_req,       // pulse: descriptor requested
    input  wire logic [7:0]           desc_req_len,   // requested length in bytes
    input  wire logic                 desc_ready,     // sink takes byte
    output logic                      desc_valid,     // byte valid
    output logic      [7:0]           desc_byte,      // descriptor byte
    output logic                      desc_last,      // last byte of transfer
    output logic      [2:0]           limit_code,     // applied limit selection
    output logic      [2:0]           limit_custom,   // applied custom limit value
    output logic                      input_block,    // stop drawing from input
    output logic                      charger_en,     // charger enable
    output logic                      sys_bat_close,  // close sys to battery switch
    output logic                      aux_supply_on,  // internal_aux_supply enable
    output logic                      ovp_irq,        // overvoltage interrupt pulse
    output logic                      bat_thr_sel     // battery threshold set select
);
    import udils_pkg::*;

    // register state
    logic [7:0]  inlim_q, inlim_d;     // input limit and sys config
    logic [7:0]  batctl_q, batctl_d;   // battery control
    logic [15:0] vid_q, vid_d;         // vendor id
    logic [15:0] pid_q, pid_d;         // product id
    logic [7:0]  rdata_q, rdata_d;     // read data
    udils_enum_t enum_q, enum_d;       // enumeration result
    // synchronisers: first stage only feeds second
    logic [1:0]  ovp_s_q, tmp_s_q;
    logic        ovp_prev_q;           // for edge of overvoltage entry
    logic        irq_q, irq_d;
    logic        blk_q, chg_q, swc_q, aux_q;
    // descriptor streaming
    udils_tx_t   tx_q, tx_d;
    logic [4:0]  idx_q, idx_d;         // current byte index
    logic [4:0]  end_q, end_d;         // last index to send
    logic        vld_q, vld_d, lst_q, lst_d;
    logic [7:0]  byt_q, byt_d;
    logic [7:0]  rom_data;
    logic [4:0]  rom_idx;

    // synchronise comparator pins
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ovp_s_q    <= 2'h0;
            tmp_s_q    <= 2'h0;
            ovp_prev_q <= 1'b0;
        end
        else
        begin
            ovp_s_q    <= {ovp_s_q[0], ovp_pin};
            tmp_s_q    <= {tmp_s_q[0], overtemp_pin};
            ovp_prev_q <= ovp_s_q[1];
        end
    end

    // register writes and hardware loads; hardware detection beats a same-cycle write
    always_comb
    begin
        inlim_d  = inlim_q;
        batctl_d = batctl_q;
        vid_d    = vid_q;
        pid_d    = pid_q;
        enum_d   = enum_q;
        rdata_d  = rdata_q;
        if (reg_wr)
        begin
            case (reg_addr)
                `UDILS_REG_INLIM:  inlim_d = reg_wdata;
                `UDILS_REG_BATCTL: batctl_d = reg_wdata;
                `UDILS_REG_VID_LO: vid_d[7:0] = reg_wdata;
                `UDILS_REG_VID_HI: vid_d[15:8] = reg_wdata;
                `UDILS_REG_PID_LO: pid_d[7:0] = reg_wdata;
                `UDILS_REG_PID_HI: pid_d[15:8] = reg_wdata;
                default:           ;                           // unmapped writes ignored
            endcase
        end
        // usb port starts at 100ma until enumeration settles
        if (usb_port)
        begin
            inlim_d[`UDILS_SEL_LSB +: `UDILS_SEL_W] = `UDILS_SEL_100MA;
            enum_d = UDILS_ENUM_IDLE;
        end
        else if (enum_done)
        begin
            inlim_d[`UDILS_SEL_LSB +: `UDILS_SEL_W] =
                host_high_pwr ? `UDILS_SEL_500MA : `UDILS_SEL_100MA;
            enum_d = host_high_pwr ? UDILS_ENUM_HIGH : UDILS_ENUM_LOW;
        end
        else if (adapter_det)
        begin
            inlim_d[`UDILS_SEL_LSB +: `UDILS_SEL_W] = adapter_sel;
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `UDILS_REG_INLIM:  rdata_d = inlim_q;
                `UDILS_REG_BATCTL: rdata_d = batctl_q;
                `UDILS_REG_VID_LO: rdata_d = vid_q[7:0];
                `UDILS_REG_VID_HI: rdata_d = vid_q[15:8];
                `UDILS_REG_PID_LO: rdata_d = pid_q[7:0];
                `UDILS_REG_PID_HI: rdata_d = pid_q[15:8];
                `UDILS_REG_STATUS: rdata_d = {4'h0, tmp_s_q[1], ovp_s_q[1], 2'(enum_q)};
                default:           rdata_d = 8'h00;            // unmapped reads zero
            endcase
        end
    end

    // register state flops
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            inlim_q  <= `UDILS_INLIM_RESET;
            batctl_q <= `UDILS_BATCTL_RESET;
            vid_q    <= `UDILS_VID_RESET;
            pid_q    <= `UDILS_PID_RESET;
            enum_q   <= UDILS_ENUM_IDLE;
            rdata_q  <= 8'h00;
        end
        else
        begin
            inlim_q  <= inlim_d;
            batctl_q <= batctl_d;
            vid_q    <= vid_d;
            pid_q    <= pid_d;
            enum_q   <= enum_d;
            rdata_q  <= rdata_d;
        end
    end

    // protection outputs from synchronised comparators
    always_comb
    begin
        irq_d = ovp_s_q[1] & ~ovp_prev_q;   // one pulse on entry
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq_q <= 1'b0;
            blk_q <= 1'b0;
            chg_q <= 1'b0;
            swc_q <= 1'b0;
            aux_q <= 1'b1;
        end
        else
        begin
            irq_q <= irq_d;
            blk_q <= tmp_s_q[1] | ovp_s_q[1];
            chg_q <= ~ovp_s_q[1];
            swc_q <= ovp_s_q[1] | tmp_s_q[1];
            aux_q <= 1'b1;                                  // aux stays up
        end
    end

    // descriptor streaming, length clipped to request and to 18
    // index from flops only, so the table lookup never loops back through the next-state logic
    assign rom_idx = (tx_q == UDILS_TX_SEND) ? idx_q + 5'h01 : 5'h00;
    udils_desc_rom u_rom
    (
        .idx  (rom_idx),
        .vid  (vid_q),
        .pid  (pid_q),
        .data (rom_data)
    );

    always_comb
    begin
        tx_d  = tx_q;
        idx_d = idx_q;
        end_d = end_q;
        vld_d = vld_q;
        lst_d = lst_q;
        byt_d = byt_q;
        case (tx_q)
            UDILS_TX_IDLE:
            begin
                if (desc_req && desc_req_len != 8'h00)
                begin
                    // last index is min(len, 18) - 1
                    end_d = (desc_req_len > `UDILS_DESC_LEN) ? 5'(`UDILS_DESC_LEN - 8'h01)
                                                             : 5'(desc_req_len - 8'h01);
                    idx_d = 5'h00;
                    tx_d  = UDILS_TX_SEND;
                    vld_d = 1'b1;
                    lst_d = (end_d == 5'h00);
                    byt_d = rom_data;
                end
            end
            UDILS_TX_SEND:
            begin
                if (desc_ready)
                begin
                    if (lst_q)
                    begin
                        tx_d  = UDILS_TX_IDLE;
                        vld_d = 1'b0;
                        lst_d = 1'b0;
                    end
                    else
                    begin
                        idx_d = idx_q + 5'h01;              // in offset order
                        lst_d = (idx_d == end_q);
                        byt_d = rom_data;
                    end
                end
            end
            default: tx_d = UDILS_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_q  <= UDILS_TX_IDLE;
            idx_q <= 5'h00;
            end_q <= 5'h00;
            vld_q <= 1'b0;
            lst_q <= 1'b0;
            byt_q <= 8'h00;
        end
        else
        begin
            tx_q  <= tx_d;
            idx_q <= idx_d;
            end_q <= end_d;
            vld_q <= vld_d;
            lst_q <= lst_d;
            byt_q <= byt_d;
        end
    end

    // outputs straight from flops
    assign reg_rdata     = rdata_q;
    assign desc_valid    = vld_q;
    assign desc_byte     = byt_q;
    assign desc_last     = lst_q;
    assign limit_code    = inlim_q[`UDILS_SEL_LSB +: `UDILS_SEL_W];
    assign limit_custom  = inlim_q[`UDILS_CUSTOM_INPUT_LIMIT_LSB +: `UDILS_CUSTOM_INPUT_LIMIT_W];
    assign input_block   = blk_q;
    assign charger_en    = chg_q;
    assign sys_bat_close = swc_q;
    assign aux_supply_on = aux_q;
    assign ovp_irq       = irq_q;
    assign bat_thr_sel   = batctl_q[`UDILS_BAT_THR_BIT];

    // checks
    AST_OVP_OFF: assert property (@(posedge clk) disable iff (rst)
        ovp_s_q[1] |=> (!charger_en && sys_bat_close && aux_supply_on))
        else $error("overvoltage did not stop charger");
    AST_OVP_IRQ: assert property (@(posedge clk) disable iff (rst)
        $rose(ovp_s_q[1]) |-> ##1 ovp_irq ##1 !ovp_irq)
        else $error("overvoltage interrupt not one pulse");
    AST_HOT: assert property (@(posedge clk) disable iff (rst)
        tmp_s_q[1] |=> input_block)
        else $error("overtemp did not block input");
    AST_USB_START: assert property (@(posedge clk) disable iff (rst)
        usb_port |=> limit_code == `UDILS_SEL_100MA)
        else $error("usb port did not start at 100ma");
    AST_ENUM_HIGH: assert property (@(posedge clk) disable iff (rst)
        (enum_done && !usb_port && host_high_pwr) |=> limit_code == `UDILS_SEL_500MA)
        else $error("high power host did not get 500ma");
    AST_DETECT: assert property (@(posedge clk) disable iff (rst)
        (adapter_det && !usb_port && !enum_done) |=> limit_code == $past(adapter_sel))
        else $error("detected adapter code not loaded");
    AST_SW_WRITE: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `UDILS_REG_INLIM && !usb_port && !enum_done && !adapter_det)
        |=> limit_code == $past(reg_wdata[2:0]) && limit_custom == $past(reg_wdata[5:3]))
        else $error("written limit not applied");
    AST_BAT_THR: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == `UDILS_REG_BATCTL) |=> bat_thr_sel == $past(reg_wdata[7]))
        else $error("threshold select not applied");
    AST_FIRST_BYTE: assert property (@(posedge clk) disable iff (rst)
        (tx_q == UDILS_TX_IDLE && desc_req && desc_req_len != 8'h00)
        |=> desc_valid && desc_byte == `UDILS_DESC_LEN)
        else $error("descriptor did not open with length");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        (desc_valid && !desc_ready) |=> desc_valid && $stable(desc_byte))
        else $error("byte dropped under stall");
endmodule

// ---- sim/udils_host_model.sv ----
// usb host model that sinks descriptor bytes, promptly or with random stalls
`timescale 1ns/1ps
module udils_host_model
(
    input  wire logic       clk,         // bench clock
    input  wire logic       stall_en,    // high: ready toggles at random
    input  wire logic       desc_valid,  // byte valid from device
    input  wire logic [7:0] desc_byte,   // byte from device
    input  wire logic       desc_last,   // last byte flag from device
    output logic            desc_ready   // host takes the byte
);
    logic [7:0] got_q[$];  // bytes in arrival order
    int         last_at;   // index of byte flagged last, -1 for none
    initial
    begin
        desc_ready = 1'b0;
        last_at    = -1;
    end
    // a byte counts only on a valid and ready edge; order kept as sent
    always @(posedge clk)
    begin
        if (desc_valid === 1'b1 && desc_ready === 1'b1)
        begin
            got_q.push_back(desc_byte);
            if (desc_last === 1'b1)
                last_at = got_q.size() - 1;
        end
        #1;
        // stalls make the device hold its byte, no kinder than a busy host
        desc_ready = stall_en ? 1'($urandom_range(0, 1)) : 1'b1;
    end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for descriptor streaming and input limit selection
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, adapter_det = 1'b0, usb_port = 1'b0;
    logic enum_done = 1'b0, host_high_pwr = 1'b0, ovp_pin = 1'b0, overtemp_pin = 1'b0, desc_req = 1'b0;
    logic stall_en = 1'b0, desc_ready, desc_valid, desc_last, input_block, charger_en;
    logic sys_bat_close, aux_supply_on, ovp_irq, bat_thr_sel;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, desc_req_len = 8'h00, reg_rdata, desc_byte, rd;
    logic [2:0]  adapter_sel = 3'h0, limit_code, limit_custom, cust;
    logic [15:0] vid, pid;
    int          num_errors = 0, checked = 0, irqs;
    logic [7:0]  reg_list [6] = '{8'h0a, 8'h10, 8'h20, 8'h21, 8'h22, 8'h23};
    logic [7:0]  len_list [5] = '{8'd18, 8'd1, 8'd2, 8'hff, 8'd9};
    always #2 clk = ~clk;
    udils_top udils_top_i (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adapter_det(adapter_det), .adapter_sel(adapter_sel),
        .usb_port(usb_port), .enum_done(enum_done), .host_high_pwr(host_high_pwr), .ovp_pin(ovp_pin),
        .overtemp_pin(overtemp_pin), .desc_req(desc_req), .desc_req_len(desc_req_len), .desc_ready(desc_ready),
        .desc_valid(desc_valid), .desc_byte(desc_byte), .desc_last(desc_last), .limit_code(limit_code),
        .limit_custom(limit_custom), .input_block(input_block), .charger_en(charger_en),
        .sys_bat_close(sys_bat_close), .aux_supply_on(aux_supply_on), .ovp_irq(ovp_irq), .bat_thr_sel(bat_thr_sel));
    udils_host_model udils_host_model_i (.clk(clk), .stall_en(stall_en), .desc_valid(desc_valid),
        .desc_byte(desc_byte), .desc_last(desc_last), .desc_ready(desc_ready));
    // inputs always change one ns after the rising edge
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    // single compare for every kind of result, unknowns never match
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    // read data is registered, seen one cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        d = reg_rdata;
        tick();
    endtask
    // one-cycle hardware event, then room for the registered update
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
        tick();
    endtask
    // reference descriptor built from the field table, words low byte first
    task automatic desc_xfer(input logic [7:0] len);
        logic [7:0] exp[$];
        int n;
        int k;
        exp = '{8'h12, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08, vid[7:0], vid[15:8],
                pid[7:0], pid[15:8], 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h01};
        n = (len > 8'd18) ? 18 : int'(len);
        udils_host_model_i.got_q.delete();
        udils_host_model_i.last_at = -1;
        desc_req_len = len;
        desc_req = 1'b1;
        tick();
        desc_req = 1'b0;
        k = 0;
        while (udils_host_model_i.last_at < 0 && k < 400)
        begin
            tick();
            k++;
        end
        repeat (3) tick();
        chk("desc_count", 16'(n), 16'(udils_host_model_i.got_q.size()));
        chk("desc_last_at", 16'(n - 1), 16'(udils_host_model_i.last_at));
        for (int i = 0; i < n && i < udils_host_model_i.got_q.size(); i++)
            chk($sformatf("desc_byte%0d", i), exp[i], udils_host_model_i.got_q[i]);
    endtask
    task automatic test_done;
        $display("counts: checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #100000;
        num_errors++;
        $display("watchdog expired");
        test_done();
    end
    initial
    begin
        void'($urandom(32'ha27e9477));
        repeat (3) tick();
        rst = 1'b0;
        tick();
        // register reset values and an unmapped address
        foreach (reg_list[i])
        begin
            reg_read(reg_list[i], rd);
            chk("reg_reset", 16'h0000, rd);
        end
        reg_write(8'h55, 8'h5a);
        reg_read(8'h55, rd);
        chk("unmapped_read", 16'h0000, rd);
        $display("test registers done");
        // ids from software, then lengths short, exact, over and random with stalls
        vid = 16'($urandom());
        pid = 16'($urandom());
        reg_write(8'h20, vid[7:0]);
        reg_write(8'h21, vid[15:8]);
        reg_write(8'h22, pid[7:0]);
        reg_write(8'h23, pid[15:8]);
        reg_read(8'h23, rd);
        chk("pid_hi_readback", pid[15:8], rd);
        stall_en = 1'b1;
        foreach (len_list[i])
            desc_xfer(len_list[i]);
        desc_xfer(8'(1 + $urandom_range(0, 16)));
        stall_en = 1'b0;
        desc_xfer(8'd18);
        $display("test descriptor done");
        // every adapter code loads the select field
        for (int c = 0; c < 8; c++)
        begin
            adapter_sel = 3'(c);
            pulse(adapter_det);
            chk("limit_code_det", 16'(c), limit_code);
            reg_read(8'h0a, rd);
            chk("inlim_sel_field", 16'(c), rd[2:0]);
        end
        cust = 3'($urandom_range(1, 6));
        reg_write(8'h0a, {2'b10, cust, 3'h1});
        tick();
        chk("limit_code_sw", 16'h0001, limit_code);
        reg_write(8'h0a, {2'b01, cust, 3'h7});
        tick();
        chk("limit_code_custom", 16'h0007, limit_code);
        chk("limit_custom", 16'(cust), limit_custom);
        $display("test input limit done");
        // usb port starts low, enumeration picks low or high power
        pulse(usb_port);
        chk("usb_start", 16'h0000, limit_code);
        host_high_pwr = 1'b1;
        pulse(enum_done);
        chk("usb_high", 16'h0001, limit_code);
        reg_read(8'h24, rd);
        chk("enum_status_high", 16'h0002, rd[1:0]);
        host_high_pwr = 1'b0;
        pulse(enum_done);
        chk("usb_low", 16'h0000, limit_code);
        reg_read(8'h24, rd);
        chk("enum_status_low", 16'h0001, rd[1:0]);
        $display("test enumeration done");
        // battery threshold set select follows bit 7 only
        reg_write(8'h10, 8'h80);
        tick();
        chk("bat_thr_on", 16'h0001, bat_thr_sel);
        reg_write(8'h10, 8'h7f);
        tick();
        chk("bat_thr_off", 16'h0000, bat_thr_sel);
        $display("test battery select done");
        // die overtemp stops input draw, battery carries the load
        overtemp_pin = 1'b1;
        repeat (6) tick();
        chk("input_block_on", 16'h0001, input_block);
        chk("sys_bat_close_temp", 16'h0001, sys_bat_close);
        overtemp_pin = 1'b0;
        repeat (6) tick();
        chk("input_block_off", 16'h0000, input_block);
        $display("test overtemp done");
        // overvoltage: one interrupt, charger off, switch closed, aux stays on
        chk("charger_before", 16'h0001, charger_en);
        ovp_pin = 1'b1;
        irqs = 0;
        repeat (12)
        begin
            tick();
            irqs += (ovp_irq === 1'b1) ? 1 : 0;
        end
        chk("ovp_irq_count", 16'h0001, 16'(irqs));
        chk("charger_off", 16'h0000, charger_en);
        chk("sys_bat_close_ovp", 16'h0001, sys_bat_close);
        chk("aux_on", 16'h0001, aux_supply_on);
        ovp_pin = 1'b0;
        repeat (6) tick();
        $display("test overvoltage done");
        test_done();
    end
endmodule
